// *** mrs_defs.svh ***
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH

// Register byte offsets
`define MRS_OFS_CTRL 4'h0
`define MRS_OFS_STATUS 4'h4
`define MRS_OFS_ACC_LO 4'h8
`define MRS_OFS_ACC_HI 4'hC

// Control field positions and reset value
`define MRS_CTRL_SUB_BIT 0
`define MRS_CTRL_HOLD_BIT 1
`define MRS_CTRL_RST 2'h0

// Status field positions
`define MRS_STAT_CNT_LSB 0
`define MRS_STAT_READY_BIT 2
`define MRS_STAT_SUB_BIT 3

`endif

// *** mrs_pkg.sv ***
package mrs_pkg;

  // Which of the four clock enables advances a stage
  typedef enum logic [1:0] {
    MRS_CLK0 = 2'h0,
    MRS_CLK1 = 2'h1,
    MRS_CLK2 = 2'h2,
    MRS_CLK3 = 2'h3
  } mrs_clk_sel_e;

  // Which of the three clears resets a stage, or none
  typedef enum logic [1:0] {
    MRS_CLR0 = 2'h0,
    MRS_CLR1 = 2'h1,
    MRS_CLR2 = 2'h2,
    MRS_CLR_NONE = 2'h3
  } mrs_clr_sel_e;

  typedef logic [3:0] mrs_clk_en_t;
  typedef logic [2:0] mrs_clr_vec_t;

endpackage

// *** mrs_stage.sv ***
`timescale 1ns/1ps

module mrs_stage #(
  parameter int W = 18,
  parameter bit EN = 1'b1,
  parameter mrs_pkg::mrs_clk_sel_e CLK_SEL = mrs_pkg::MRS_CLK0,
  parameter mrs_pkg::mrs_clr_sel_e CLR_SEL = mrs_pkg::MRS_CLR_NONE
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire mrs_pkg::mrs_clk_en_t clock_enable_i,
  input wire mrs_pkg::mrs_clr_vec_t clear_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import mrs_pkg::*;

  generate
    if (EN) begin : g_reg
      logic [W-1:0] q;
      logic [W-1:0] next_q;
      logic clr;
      logic stage_rst_n;
      logic [3:0] clr_pad;

      // A stage with no clear source reads the padded bit, which is never set
      assign clr_pad = {1'b0, clear_i};
      assign clr = clr_pad[CLR_SEL];
      // Clear acts at once, whatever the enable; the combined reset must be glitch free
      assign stage_rst_n = rst_n_i & ~clr;

      // RQ7 one cycle per enable
      always_comb begin
        next_q = q;
        if (clock_enable_i[CLK_SEL]) begin
          next_q = d_i;
        end
      end

      always_ff @(posedge clk_i or negedge stage_rst_n) begin
        if (!stage_rst_n) begin
          q <= '0;
        end else begin
          q <= next_q;
        end
      end

      assign q_o = q;
    end else begin : g_bypass
      // RQ7 bypass adds no latency
      assign q_o = d_i;
    end
  endgenerate

endmodule

// *** mrs_mac_top.sv ***
`timescale 1ns/1ps
`include "mrs_defs.svh"

// Summary of operation
// RQ1 - A build option inserts or bypasses a register on operand A, with one of four clocks and one of three clears or none.
// RQ2 - A separate build option does the same for operand B, with its clock and clear chosen independently.
// RQ3 - An optional register right after the multiplier captures the product, with its own clock and clear choice.
// RQ4 - The multiplier always takes both operands from the block's own operand buses, registered or not.
// RQ5 - With sync load high the accumulator loads the product when adding, or its negation when subtracting.
// RQ6 - Each clear input is active high and resets every register assigned to it regardless of its clock.
// RQ7 - Each enabled stage adds exactly one cycle of its selected clock, a bypassed stage adds none.

module mrs_mac_top #(
  parameter int WA = 18,
  parameter int WB = 18,
  parameter int AW = 52,
  parameter bit A_REG_EN = 1'b1,
  parameter mrs_pkg::mrs_clk_sel_e A_CLK_SEL = mrs_pkg::MRS_CLK0,
  parameter mrs_pkg::mrs_clr_sel_e A_CLR_SEL = mrs_pkg::MRS_CLR0,
  parameter bit B_REG_EN = 1'b1,
  parameter mrs_pkg::mrs_clk_sel_e B_CLK_SEL = mrs_pkg::MRS_CLK0,
  parameter mrs_pkg::mrs_clr_sel_e B_CLR_SEL = mrs_pkg::MRS_CLR0,
  parameter bit P_REG_EN = 1'b1,
  parameter mrs_pkg::mrs_clk_sel_e P_CLK_SEL = mrs_pkg::MRS_CLK0,
  parameter mrs_pkg::mrs_clr_sel_e P_CLR_SEL = mrs_pkg::MRS_CLR0,
  parameter mrs_pkg::mrs_clk_sel_e ACC_CLK_SEL = mrs_pkg::MRS_CLK0,
  parameter mrs_pkg::mrs_clr_sel_e ACC_CLR_SEL = mrs_pkg::MRS_CLR0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire mrs_pkg::mrs_clk_en_t clock_enable_i,
  input wire logic async_clear_first_i,
  input wire logic async_clear_second_i,
  input wire logic async_clear_third_i,
  input wire logic [WA-1:0] operand_a_i,
  input wire logic [WB-1:0] operand_b_i,
  input wire logic accum_sload_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [AW-1:0] acc_data_o,
  output logic acc_valid_o,
  input wire logic acc_ready_i,
  output logic step_ready_o
);
  import mrs_pkg::*;

  localparam int PW = WA + WB;

  // ****************************************
  // Operand and product stages
  // ****************************************
  mrs_clr_vec_t clear_vec;
  logic [3:0] clr_pad;
  logic [WA-1:0] opa_q;
  logic [WB-1:0] opb_q;
  logic [PW-1:0] prod_raw;
  logic [PW-1:0] prod_q;

  assign clear_vec = {async_clear_third_i, async_clear_second_i, async_clear_first_i};
  // Top bit stands for the none choice, so no clear select runs out of range
  assign clr_pad = {1'b0, clear_vec};

  // RQ1 operand A stage
  mrs_stage #(.W(WA), .EN(A_REG_EN), .CLK_SEL(A_CLK_SEL), .CLR_SEL(A_CLR_SEL)) u_stage_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clock_enable_i(clock_enable_i),
    .clear_i(clear_vec),
    .d_i(operand_a_i),
    .q_o(opa_q)
  );

  // RQ2 operand B stage
  mrs_stage #(.W(WB), .EN(B_REG_EN), .CLK_SEL(B_CLK_SEL), .CLR_SEL(B_CLR_SEL)) u_stage_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clock_enable_i(clock_enable_i),
    .clear_i(clear_vec),
    .d_i(operand_b_i),
    .q_o(opb_q)
  );

  // RQ4 operands only from own buses
  assign prod_raw = PW'(opa_q) * PW'(opb_q);

  // RQ3 product stage
  mrs_stage #(.W(PW), .EN(P_REG_EN), .CLK_SEL(P_CLK_SEL), .CLR_SEL(P_CLR_SEL)) u_stage_p (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clock_enable_i(clock_enable_i),
    .clear_i(clear_vec),
    .d_i(prod_raw),
    .q_o(prod_q)
  );

  // ****************************************
  // Control registers
  // ****************************************
  logic ctrl_sub;
  logic ctrl_hold;
  logic next_ctrl_sub;
  logic next_ctrl_hold;
  logic [31:0] next_readdata;
  logic next_wait;
  logic bus_req;
  logic bus_write_now;
  logic [1:0] buf_cnt;
  logic [AW-1:0] acc;

  assign bus_req = avs_read_i | avs_write_i;
  // A write lands only at the edge where waitrequest is seen low
  assign bus_write_now = avs_write_i & ~avs_waitrequest_o;

  always_comb begin
    next_ctrl_sub = ctrl_sub;
    next_ctrl_hold = ctrl_hold;
    next_wait = 1'b1;
    next_readdata = avs_readdata_o;
    if (bus_write_now && avs_address_i == `MRS_OFS_CTRL) begin
      next_ctrl_sub = avs_writedata_i[`MRS_CTRL_SUB_BIT];
      next_ctrl_hold = avs_writedata_i[`MRS_CTRL_HOLD_BIT];
    end
    // One wait cycle per request, then a single ready cycle
    if (bus_req && avs_waitrequest_o) begin
      next_wait = 1'b0;
    end
    if (avs_read_i && avs_waitrequest_o) begin
      if (avs_address_i == `MRS_OFS_CTRL) begin
        next_readdata = {30'h0, ctrl_hold, ctrl_sub};
      end else if (avs_address_i == `MRS_OFS_STATUS) begin
        next_readdata = {28'h0, ctrl_sub, step_ready_o, buf_cnt};
      end else if (avs_address_i == `MRS_OFS_ACC_LO) begin
        next_readdata = acc[31:0];
      end else if (avs_address_i == `MRS_OFS_ACC_HI) begin
        next_readdata = 32'(acc[AW-1:32]);
      end else begin
        next_readdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_sub <= 1'b0;
      ctrl_hold <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      ctrl_sub <= next_ctrl_sub;
      ctrl_hold <= next_ctrl_hold;
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_readdata;
    end
  end

  // ****************************************
  // Accumulator
  // ****************************************
  logic [AW-1:0] next_acc;
  logic [AW-1:0] prod_ext;
  logic acc_step;
  logic acc_clr;
  logic acc_rst_n;

  assign prod_ext = AW'(prod_q);
  // A full buffer stalls the accumulator so no result is dropped
  assign acc_step = clock_enable_i[ACC_CLK_SEL] & step_ready_o & ~ctrl_hold;
  assign acc_clr = clr_pad[ACC_CLR_SEL];
  // RQ6 clear acts without clock
  assign acc_rst_n = rst_n_i & ~acc_clr;

  always_comb begin
    next_acc = acc;
    if (acc_step) begin
      // RQ5 sync load of product
      if (accum_sload_i) begin
        next_acc = ctrl_sub ? AW'(-prod_ext) : prod_ext;
      end else begin
        next_acc = ctrl_sub ? AW'(acc - prod_ext) : AW'(acc + prod_ext);
      end
    end
  end

  always_ff @(posedge clk_i or negedge acc_rst_n) begin
    if (!acc_rst_n) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // ****************************************
  // Two-entry result buffer
  // ****************************************
  logic [AW-1:0] buf0;
  logic [AW-1:0] buf1;
  logic [AW-1:0] next_buf0;
  logic [AW-1:0] next_buf1;
  logic [1:0] next_cnt;
  logic pop;

  assign pop = acc_valid_o & acc_ready_i;

  always_comb begin
    next_buf0 = buf0;
    next_buf1 = buf1;
    next_cnt = buf_cnt;
    case ({acc_step, pop})
      2'b10: begin
        if (buf_cnt == 2'h0) begin
          next_buf0 = next_acc;
        end else begin
          next_buf1 = next_acc;
        end
        next_cnt = buf_cnt + 2'h1;
      end
      2'b01: begin
        next_buf0 = buf1;
        next_cnt = buf_cnt - 2'h1;
      end
      2'b11: begin
        if (buf_cnt == 2'h1) begin
          next_buf0 = next_acc;
        end else begin
          next_buf0 = buf1;
          next_buf1 = next_acc;
        end
      end
      default: begin
        next_cnt = buf_cnt;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf0 <= '0;
      buf1 <= '0;
      buf_cnt <= 2'h0;
      acc_valid_o <= 1'b0;
      step_ready_o <= 1'b1;
      acc_data_o <= '0;
    end else begin
      buf0 <= next_buf0;
      buf1 <= next_buf1;
      buf_cnt <= next_cnt;
      acc_valid_o <= (next_cnt != 2'h0);
      step_ready_o <= (next_cnt != 2'h2);
      acc_data_o <= next_buf0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic clr_a;
  logic clr_b;
  logic clr_p;
  assign clr_a = clr_pad[A_CLR_SEL];
  assign clr_b = clr_pad[B_CLR_SEL];
  assign clr_p = clr_pad[P_CLR_SEL];

  a_stage_a_latency: assert property ( // RQ1
    (A_REG_EN && clock_enable_i[A_CLK_SEL] && !clr_a) ##1 !clr_a |-> opa_q == $past(operand_a_i)
  ) else $error("operand A stage did not take its input");

  a_stage_a_hold: assert property ( // RQ7
    (A_REG_EN && !clock_enable_i[A_CLK_SEL] && !clr_a) ##1 !clr_a |-> $stable(opa_q)
  ) else $error("operand A stage moved without its enable");

  a_stage_b_latency: assert property ( // RQ2
    (B_REG_EN && clock_enable_i[B_CLK_SEL] && !clr_b) ##1 !clr_b |-> opb_q == $past(operand_b_i)
  ) else $error("operand B stage did not take its input");

  a_bypass_b_direct: assert property ( // RQ7
    !B_REG_EN |-> opb_q == operand_b_i
  ) else $error("bypassed operand B stage adds latency");

  a_product_stage: assert property ( // RQ3
    (P_REG_EN && clock_enable_i[P_CLK_SEL] && !clr_p) ##1 !clr_p |-> prod_q == $past(prod_raw)
  ) else $error("product stage did not capture product");

  a_product_source: assert property ( // RQ4
    (!A_REG_EN && !B_REG_EN && !P_REG_EN) |-> prod_q == PW'(operand_a_i) * PW'(operand_b_i)
  ) else $error("product not formed from operand buses");

  a_sload_add: assert property ( // RQ5
    (acc_step && accum_sload_i && !ctrl_sub && !acc_clr) ##1 !acc_clr |-> acc == $past(prod_ext)
  ) else $error("sync load did not load product");

  a_sload_sub: assert property ( // RQ5
    (acc_step && accum_sload_i && ctrl_sub && !acc_clr) ##1 !acc_clr
      |-> AW'(acc + $past(prod_ext)) == '0
  ) else $error("sync load did not load negated product");

  a_clear_a_zero: assert property ( // RQ6
    (A_REG_EN && clr_a) |-> opa_q == '0
  ) else $error("clear did not reset operand A stage");

  a_buf_stall: assert property (
    acc_valid_o && !acc_ready_i |=> acc_valid_o && $stable(acc_data_o)
  ) else $error("buffer lost data under stall");

  a_bus_single_wait: assert property (
    bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o
  ) else $error("bus answer not after one wait cycle");

  c_sload_sub: cover property (acc_step && accum_sload_i && ctrl_sub);
  c_buf_full: cover property (!step_ready_o ##1 pop);
  c_clear_hit: cover property (clr_a ##1 !clr_a);
  c_bus_write: cover property (bus_write_now && avs_address_i == `MRS_OFS_CTRL);

endmodule

// *** mrs_user_logic.sv ***
`timescale 1ns/1ps

// ****************************************
// User logic model on the far side
// ****************************************
module mrs_user_logic (
  input wire logic clk_i,
  input wire logic en_mode_i,
  input wire logic rdy_mode_i,
  input wire logic [2:0] clr_req_i,
  output logic [3:0] clock_enable_o,
  output logic [2:0] clear_o,
  output logic [17:0] operand_a_o,
  output logic [17:0] operand_b_o,
  output logic sload_o,
  output logic acc_ready_o
);
  integer seed = 39867;

  initial begin
    {clock_enable_o, clear_o, operand_a_o, operand_b_o, sload_o, acc_ready_o} = '0;
  end

  // Random enables and stalls keep every stage and the buffer busy
  always @(posedge clk_i) begin
    clock_enable_o <= en_mode_i ? 4'($random(seed)) : 4'h0;
    clear_o <= clr_req_i;
    operand_a_o <= 18'($random(seed));
    operand_b_o <= 18'($random(seed));
    sload_o <= 1'($random(seed));
    acc_ready_o <= rdy_mode_i & 1'($random(seed));
  end
endmodule

// *** tb_mult_accum_register_stages.sv ***
`timescale 1ns/1ps

module tb_mult_accum_register_stages;
  import mrs_pkg::*;
  localparam int AW = 52;
  logic clk_i, rst_n_i, en_mode, rdy_mode, sload, rdy;
  logic [2:0] clr_req, clr;
  mrs_clk_en_t en;
  logic [17:0] opa_in, opb_in, m_a, m_b;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, acc_valid, step_ready, m_sub, m_hold;
  logic [31:0] avs_writedata, avs_readdata;
  logic [AW-1:0] acc_data, m_acc;
  logic [35:0] m_p;
  logic [1:0] m_cnt;
  logic [AW-1:0] exp_q[$];
  logic [AW-1:0] acc_data2, m2_acc;
  logic acc_valid2, step_ready2;
  logic [1:0] m2_cnt;
  logic [AW-1:0] exp2_q[$];
  int err_count = 0;
  int cmp_count = 0;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  mrs_user_logic PEER (.clk_i(clk_i), .en_mode_i(en_mode), .rdy_mode_i(rdy_mode),
    .clr_req_i(clr_req), .clock_enable_o(en), .clear_o(clr), .operand_a_o(opa_in),
    .operand_b_o(opb_in), .sload_o(sload), .acc_ready_o(rdy));

  mrs_mac_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .clock_enable_i(en),
    .async_clear_first_i(clr[0]), .async_clear_second_i(clr[1]),
    .async_clear_third_i(clr[2]), .operand_a_i(opa_in), .operand_b_i(opb_in),
    .accum_sload_i(sload), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .acc_data_o(acc_data), .acc_valid_o(acc_valid),
    .acc_ready_i(rdy), .step_ready_o(step_ready));

  // Second build: every stage bypassed, accumulator on clock 3 with no clear
  mrs_mac_top #(.A_REG_EN(1'b0), .B_REG_EN(1'b0), .P_REG_EN(1'b0), .ACC_CLK_SEL(MRS_CLK3),
    .ACC_CLR_SEL(MRS_CLR_NONE)) DUT2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .clock_enable_i(en),
    .async_clear_first_i(clr[0]), .async_clear_second_i(clr[1]),
    .async_clear_third_i(clr[2]), .operand_a_i(opa_in), .operand_b_i(opb_in),
    .accum_sload_i(sload), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(),
    .avs_waitrequest_o(), .acc_data_o(acc_data2), .acc_valid_o(acc_valid2),
    .acc_ready_i(rdy), .step_ready_o(step_ready2));

  // ****************************************
  // Checking and reference model
  // ****************************************
  task automatic check(input bit ok, input string what);
    cmp_count++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Steps only from the model's own buffer count, never from the design's flags
  always @(posedge clk_i or negedge rst_n_i) begin
    logic step, pop;
    if (!rst_n_i) begin
      {m_a, m_b, m_p, m_acc, m_cnt} = '0;
    end else begin
      step = en[0] && m_cnt != 2'h2 && !m_hold;
      pop = m_cnt != 2'h0 && rdy;
      if (clr[0]) {m_a, m_b, m_p, m_acc} = '0;
      else begin
        if (step && sload) m_acc = m_sub ? -AW'(m_p) : AW'(m_p);
        else if (step) m_acc = m_sub ? m_acc - AW'(m_p) : m_acc + AW'(m_p);
        if (en[0]) begin
          m_p = m_a * m_b;
          m_a = opa_in;
          m_b = opb_in;
        end
      end
      if (step) exp_q.push_back(m_acc);
      m_cnt = m_cnt + 2'(step) - 2'(pop);
    end
  end

  // Bypassed build: product straight from the buses, clears never reach it
  always @(posedge clk_i or negedge rst_n_i) begin
    logic step, pop;
    logic [35:0] p;
    if (!rst_n_i) begin
      {m2_acc, m2_cnt} = '0;
    end else begin
      step = en[3] && m2_cnt != 2'h2 && !m_hold;
      pop = m2_cnt != 2'h0 && rdy;
      p = opa_in * opb_in;
      if (step && sload) m2_acc = m_sub ? -AW'(p) : AW'(p);
      else if (step) m2_acc = m_sub ? m2_acc - AW'(p) : m2_acc + AW'(p);
      if (step) exp2_q.push_back(m2_acc);
      m2_cnt = m2_cnt + 2'(step) - 2'(pop);
    end
  end

  always @(posedge clk_i) begin
    if (rst_n_i && acc_valid === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "word without a step");
      else check(acc_data === exp_q.pop_front(), "stream word");
    end
    if (rst_n_i && acc_valid2 === 1'b1 && rdy === 1'b1) begin
      if (exp2_q.size() == 0) check(1'b0, "bypass word without a step");
      else check(acc_data2 === exp2_q.pop_front(), "bypass stream word");
    end
  end

  always @(negedge clk_i) begin
    if (rst_n_i) begin
      check(acc_valid === (m_cnt != 2'h0), "valid flag");
      check(step_ready === (m_cnt != 2'h2), "not-full flag");
      check(acc_valid2 === (m2_cnt != 2'h0), "bypass valid flag");
      check(step_ready2 === (m2_cnt != 2'h2), "bypass not-full flag");
    end
  end

  // ****************************************
  // Bus and traffic tasks
  // ****************************************
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) check(1'b0, "bus answer missing");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Control writes only while enables are off, so the model never races them
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a == 4'h0) {m_hold, m_sub} = d[1:0];
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q === e, what);
  endtask

  task automatic run(input logic e, input logic r, input int n);
    en_mode <= e;
    rdy_mode <= r;
    repeat (n) @(posedge clk_i);
  endtask

  initial begin
    #100000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {en_mode, rdy_mode, clr_req, m_sub, m_hold} = '0;
    rst_n_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    check(avs_waitrequest === 1'b1 && step_ready === 1'b1, "reset outputs");
    rd_reg(4'h0, 32'h0, "ctrl reset");
    rd_reg(4'h2, 32'h0, "unmapped read");
    wr_reg(4'h4, 32'hF);
    rd_reg(4'h4, 32'h4, "status read only");
    $display("test registers done");
    run(1'b1, 1'b1, 300);
    run(1'b1, 1'b0, 30);
    rd_reg(4'h4, 32'h2, "full status");
    run(1'b0, 1'b1, 20);
    rd_reg(4'h4, 32'h4, "drained status");
    rd_reg(4'h8, m_acc[31:0], "acc low");
    rd_reg(4'hC, 32'(m_acc[AW-1:32]), "acc high");
    $display("test accumulate and stall done");
    wr_reg(4'h0, 32'h1);
    run(1'b1, 1'b1, 200);
    run(1'b0, 1'b1, 10);
    rd_reg(4'h4, 32'hC, "subtract status");
    wr_reg(4'h0, 32'h3);
    run(1'b1, 1'b1, 50);
    run(1'b0, 1'b1, 10);
    wr_reg(4'h0, 32'h0);
    $display("test subtract and hold done");
    clr_req <= 3'h6;
    run(1'b0, 1'b1, 4);
    clr_req <= 3'h0;
    run(1'b0, 1'b1, 3);
    rd_reg(4'h8, m_acc[31:0], "other clears ignored");
    clr_req <= 3'h1;
    run(1'b0, 1'b1, 4);
    clr_req <= 3'h0;
    run(1'b0, 1'b1, 3);
    rd_reg(4'h8, 32'h0, "first clear zeroes");
    run(1'b1, 1'b1, 100);
    run(1'b0, 1'b1, 10);
    $display("test clears done");
    wrap_up();
  end
endmodule
